/* design/snl_link.sv */
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module snl_link
  import snl_pkg::*;
#(
  parameter int RX_CNT_W = 16
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [2:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_we,
  input wire logic bus_re,
  output logic [15:0] bus_rdata,
  input wire logic sent_rx_in,
  output logic sent_tx_out,
  output logic frame_done
);

  // the tick decoder is built for a 16 bit interval count
  if (RX_CNT_W != 16) begin : g_bad_w
    $error("RX_CNT_W must be 16");
  end

  logic [15:0] ctl_q, ctl_d, tmx_q, tmx_d, fms_q, fms_d;
  logic [15:0] sync_q, sync_d, dh_q, dh_d, dl_q, dl_d;
  logic [15:0] rdata_q, rdata_d;
  logic [3:0] stat_q, stat_d;
  logic done_q, done_d, line_q, line_d;
  snl_tx_st_t txs_q, txs_d;
  logic [15:0] tdiv_q, tdiv_d;
  logic [9:0] tpos_q, tpos_d, tlen_q, tlen_d;
  logic [3:0] tseq_q, tseq_d;
  logic [11:0] tused_q, tused_d;
  logic [31:0] tbuf_q, tbuf_d;
  snl_rx_st_t rxs_q, rxs_d;
  logic rprev_q, rprev_d;
  logic [RX_CNT_W-1:0] rcnt_q, rcnt_d;
  logic [3:0] rseq_q, rseq_d;
  logic [31:0] rbuf_q, rbuf_d;

  logic en, rxm, trg, pol, crce, pse, tick, tx_go;
  logic fall, in_sync, nib_ok, rx_last;
  logic [2:0] nn;
  logic [3:0] seq_crc, seq_pse, rnib, rx_crc;
  logic [9:0] rx_ticks, pse_len;
  logic [15:0] flen;
  logic [16:0] rem;
  logic [11:0] used_nx;

  // control decode
  assign en = ctl_q[CTL_EN];
  assign rxm = ctl_q[CTL_RX];
  assign trg = ctl_q[CTL_TRG];
  assign pol = ctl_q[CTL_POL];
  assign crce = ctl_q[CTL_CRC];
  assign pse = ctl_q[CTL_PSE];
  assign nn = snl_nibs(ctl_q[CTL_NIB +: 3]);
  assign seq_crc = {1'b0, nn} + 4'h2;
  assign seq_pse = seq_crc + 4'h1;

  // one tick every divider plus one clocks
  assign tick = (tdiv_q == tmx_q);
  assign tx_go = !trg || stat_q[ST_TRG];

  // pause fills the frame in continuous mode (12 ticks when triggered), but never below 12 or above 768 ticks
  assign flen = (fms_q > FRAME_CAP) ? 16'h0000 : fms_q;
  assign used_nx = tused_q + {2'h0, tlen_q};
  assign rem = {1'b0, flen} - {5'h00, used_nx};
  assign pse_len = trg ? PAUSE_MIN :
                   (rem[16] || rem < {7'h00, PAUSE_MIN}) ? PAUSE_MIN :
                   (rem > {7'h00, PAUSE_MAX}) ? PAUSE_MAX : rem[9:0];

  // receive side measurement between falling edges
  assign fall = rprev_q && !sent_rx_in;
  assign in_sync = (rcnt_q >= fms_q) && (rcnt_q <= tmx_q);
  assign rx_ticks = snl_ticks(rcnt_q, sync_q);
  assign nib_ok = (rx_ticks >= NIB_BASE) && (rx_ticks <= NIB_MAX);
  assign rnib = 4'(rx_ticks - NIB_BASE);
  assign rx_last = (rseq_q == {1'b0, nn} + 4'h1);
  assign rx_crc = snl_crc(rbuf_q[27:4], nn);

  // next state for registers, transmitter and receiver
  always_comb begin
    logic start;
    logic tx_done;
    logic rx_done;
    logic crc_bad;
    logic ferr;
    logic [3:0] nsq;
    logic [2:0] k;
    start = 1'b0;
    tx_done = 1'b0;
    rx_done = 1'b0;
    crc_bad = 1'b0;
    ferr = 1'b0;
    nsq = 4'h0;
    k = 3'h0;
    ctl_d = ctl_q;
    tmx_d = tmx_q;
    fms_d = fms_q;
    sync_d = sync_q;
    dh_d = dh_q;
    dl_d = dl_q;
    rdata_d = rdata_q;
    stat_d = stat_q;
    done_d = done_q;
    line_d = line_q;
    txs_d = txs_q;
    tdiv_d = tdiv_q;
    tpos_d = tpos_q;
    tlen_d = tlen_q;
    tseq_d = tseq_q;
    tused_d = tused_q;
    tbuf_d = tbuf_q;
    rxs_d = rxs_q;
    rprev_d = rprev_q;
    rcnt_d = rcnt_q;
    rseq_d = rseq_q;
    rbuf_d = rbuf_q;
    if (ce) begin
      rdata_d = 16'h0000;
      done_d = 1'b0;
      tdiv_d = tick ? 16'h0000 : tdiv_q + 16'h0001;
      // transmitter sequencing, one interval per nibble
      if (!en || rxm) begin
        txs_d = TX_IDLE;
      end else begin
        case (txs_q)
          TX_IDLE: begin
            start = tx_go;
          end
          TX_RUN: begin
            if (tick && (tpos_q + 10'h001 < tlen_q)) begin
              tpos_d = tpos_q + 10'h001;
            end else if (tick) begin
              tpos_d = 10'h000;
              tused_d = used_nx;
              nsq = tseq_q + 4'h1;
              if (tseq_q == seq_crc) begin
                tx_done = 1'b1;
              end
              if ((pse && tseq_q == seq_pse) || (!pse && tseq_q == seq_crc)) begin
                // back to back frames share the closing edge
                if (trg) begin
                  txs_d = TX_TAIL;
                end else begin
                  start = 1'b1;
                end
              end else begin
                tseq_d = nsq;
                k = (nsq == seq_crc) ? 3'h7 : 3'(nsq - 4'h1);
                tlen_d = (nsq == seq_pse) ? pse_len :
                         NIB_BASE + {6'h00, tbuf_q[31 - 4 * k -: 4]};
              end
            end
          end
          TX_TAIL: begin
            // closing edge so the last interval is delimited
            if (tick && (tpos_q + 10'h001 < LOW_TICKS)) begin
              tpos_d = tpos_q + 10'h001;
            end else if (tick) begin
              txs_d = TX_IDLE;
            end
          end
          default: begin
            txs_d = TX_IDLE;
          end
        endcase
      end
      // frame start: latch one whole frame so software may rewrite data
      if (start) begin
        txs_d = TX_RUN;
        tseq_d = 4'h0;
        tlen_d = SYNC_TICKS;
        tpos_d = 10'h000;
        tused_d = 12'h000;
        tdiv_d = 16'h0000;
        tbuf_d = {dh_q, dl_q[15:4],
                  crce ? snl_crc({dh_q[11:0], dl_q[15:4]}, nn) : dl_q[3:0]};
        stat_d[ST_TRG] = 1'b0;
      end
      // register reads, answered in the next cycle
      if (bus_re) begin
        case (bus_addr)
          REG_CTL: rdata_d = ctl_q;
          REG_TICK: rdata_d = tmx_q;
          REG_FRAME: rdata_d = fms_q;
          REG_STAT: rdata_d = {12'h000, stat_q};
          REG_SYNC: rdata_d = sync_q;
          REG_DATH: rdata_d = dh_q;
          REG_DATL: rdata_d = dl_q;
          REG_INFO: rdata_d = {txs_q, rxs_q, 4'h0, tseq_q, rseq_q};
          default: rdata_d = 16'h0000;
        endcase
      end
      // register writes; trigger set beats the hardware clear above
      if (bus_we) begin
        case (bus_addr)
          REG_CTL: ctl_d = bus_wdata & CTL_WMASK;
          REG_TICK: tmx_d = bus_wdata;
          REG_FRAME: fms_d = bus_wdata;
          REG_STAT: begin
            stat_d[ST_TRG] = stat_d[ST_TRG] | bus_wdata[ST_TRG];
            stat_d[ST_DONE +: 3] = stat_q[ST_DONE +: 3] & ~bus_wdata[ST_DONE +: 3];
          end
          REG_DATH: dh_d = bus_wdata;
          REG_DATL: dl_d = bus_wdata;
          default: begin
          end
        endcase
      end
      // receiver: interval count saturates so long gaps fail decode
      rprev_d = sent_rx_in;
      rcnt_d = fall ? 16'h0001 : (&rcnt_q) ? rcnt_q : rcnt_q + 16'h0001;
      if (!en || !rxm) begin
        rxs_d = RX_HUNT;
      end else if (fall) begin
        case (rxs_q)
          RX_HUNT: begin
            if (in_sync) begin
              sync_d = rcnt_q;
              rxs_d = RX_NIB;
              rseq_d = 4'h0;
              rbuf_d = 32'h00000000;
            end
          end
          RX_NIB: begin
            if (!nib_ok) begin
              ferr = 1'b1;
              rxs_d = RX_HUNT;
            end else if (rx_last) begin
              // whole frame lands at once, after the crc nibble
              dh_d = rbuf_q[31:16];
              dl_d = {rbuf_q[15:4], rnib};
              rx_done = 1'b1;
              crc_bad = crce && (rx_crc != rnib);
              rxs_d = pse ? RX_PAUSE : RX_HUNT;
            end else begin
              rbuf_d[31 - 4 * rseq_q -: 4] = rnib;
              rseq_d = rseq_q + 4'h1;
            end
          end
          RX_PAUSE: begin
            if (rx_ticks < PAUSE_MIN || rx_ticks > PAUSE_MAX) begin
              ferr = 1'b1;
            end
            rxs_d = RX_HUNT;
          end
          default: begin
            rxs_d = RX_HUNT;
          end
        endcase
      end
      // sticky flags: a hardware set beats a software clear
      if (tx_done || rx_done) begin
        stat_d[ST_DONE] = 1'b1;
        done_d = 1'b1;
      end
      if (crc_bad) begin
        stat_d[ST_CRC] = 1'b1;
      end
      if (ferr) begin
        stat_d[ST_FERR] = 1'b1;
      end
      // line low for the first ticks of each interval, xor polarity
      line_d = (txs_d == TX_IDLE) ? ~pol : (tpos_d < LOW_TICKS) ? pol : ~pol;
    end
  end

  // state registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ctl_q <= REG_RST;
      tmx_q <= REG_RST;
      fms_q <= REG_RST;
      sync_q <= REG_RST;
      dh_q <= REG_RST;
      dl_q <= REG_RST;
      rdata_q <= REG_RST;
      stat_q <= 4'h0;
      done_q <= 1'b0;
      line_q <= 1'b1;
      txs_q <= TX_IDLE;
      tdiv_q <= 16'h0000;
      tpos_q <= 10'h000;
      tlen_q <= 10'h000;
      tseq_q <= 4'h0;
      tused_q <= 12'h000;
      tbuf_q <= 32'h00000000;
      rxs_q <= RX_HUNT;
      rprev_q <= 1'b0;
      rcnt_q <= 16'h0000;
      rseq_q <= 4'h0;
      rbuf_q <= 32'h00000000;
    end else begin
      ctl_q <= ctl_d;
      tmx_q <= tmx_d;
      fms_q <= fms_d;
      sync_q <= sync_d;
      dh_q <= dh_d;
      dl_q <= dl_d;
      rdata_q <= rdata_d;
      stat_q <= stat_d;
      done_q <= done_d;
      line_q <= line_d;
      txs_q <= txs_d;
      tdiv_q <= tdiv_d;
      tpos_q <= tpos_d;
      tlen_q <= tlen_d;
      tseq_q <= tseq_d;
      tused_q <= tused_d;
      tbuf_q <= tbuf_d;
      rxs_q <= rxs_d;
      rprev_q <= rprev_d;
      rcnt_q <= rcnt_d;
      rseq_q <= rseq_d;
      rbuf_q <= rbuf_d;
    end
  end

  assign bus_rdata = rdata_q;
  assign sent_tx_out = line_q;
  assign frame_done = done_q;

  // checks on the design's own behaviour
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_tx_start;
    ce && txs_q != TX_RUN ##1 txs_q == TX_RUN;
  endsequence

  sequence s_rx_edge;
    ce && en && rxm && fall;
  endsequence

  sequence s_rx_last;
    s_rx_edge and (rxs_q == RX_NIB && nib_ok && rx_last);
  endsequence

  a_sync_first: assert property (s_tx_start |-> tlen_q == SYNC_TICKS && tseq_q == 4'h0)
    else $error("frame does not open with a sync interval");
  a_trig_gate: assert property (s_tx_start |-> $past(!trg || stat_q[ST_TRG]))
    else $error("frame started without a trigger");
  a_nib_width: assert property (txs_q == TX_RUN && tseq_q != 4'h0 && tseq_q <= seq_crc
    |-> tlen_q >= NIB_BASE && tlen_q <= NIB_MAX)
    else $error("nibble interval outside 12 to 27 ticks");
  a_pause_range: assert property (txs_q == TX_RUN && pse && tseq_q == seq_pse
    |-> tlen_q >= PAUSE_MIN && tlen_q <= PAUSE_MAX)
    else $error("pause interval out of range");
  a_tick_wrap: assert property (ce && txs_q == TX_RUN && tick ##1 ce
    |-> tdiv_q == 16'h0000 ##1 (tdiv_q == 16'h0001 || !ce || tick))
    else $error("tick divider did not restart");
  a_idle_level: assert property (ce && (!en || rxm) ##1 ce |-> line_q == ~$past(pol))
    else $error("idle line level wrong");
  a_sync_capture: assert property (s_rx_edge and (rxs_q == RX_HUNT && in_sync)
    |=> rxs_q == RX_NIB && sync_q == $past(rcnt_q) && rseq_q == 4'h0)
    else $error("valid sync not captured");
  a_frame_err: assert property (s_rx_edge and (rxs_q == RX_NIB && !nib_ok)
    |=> stat_q[ST_FERR] && rxs_q == RX_HUNT)
    else $error("framing error not reported");
  a_rx_done: assert property (s_rx_last |=> done_q && stat_q[ST_DONE] && dl_q[3:0] == $past(rnib)
    ##1 !done_q || $past(!ce))
    else $error("frame completion not signalled");
  a_crc_err: assert property (s_rx_last and (crce && rx_crc != rnib) |=> stat_q[ST_CRC])
    else $error("crc mismatch not flagged");

endmodule

/* design/snl_pkg.sv */
package snl_pkg;

  // register index on the plain port
  localparam logic [2:0] REG_CTL = 3'h0;
  localparam logic [2:0] REG_TICK = 3'h1;
  localparam logic [2:0] REG_FRAME = 3'h2;
  localparam logic [2:0] REG_STAT = 3'h3;
  localparam logic [2:0] REG_SYNC = 3'h4;
  localparam logic [2:0] REG_DATH = 3'h5;
  localparam logic [2:0] REG_DATL = 3'h6;
  localparam logic [2:0] REG_INFO = 3'h7;

  // control fields, status flags
  localparam int CTL_EN = 15;
  localparam int CTL_RX = 11;
  localparam int CTL_TRG = 10;
  localparam int CTL_POL = 9;
  localparam int CTL_CRC = 8;
  localparam int CTL_PSE = 7;
  localparam int CTL_NIB = 0;
  localparam logic [15:0] CTL_WMASK = 16'h8F87;
  localparam int ST_TRG = 0;
  localparam int ST_DONE = 1;
  localparam int ST_CRC = 2;
  localparam int ST_FERR = 3;
  localparam logic [15:0] REG_RST = 16'h0000;

  // interval lengths in ticks, frame cap, nibble count range, crc seed and polynomial
  localparam logic [9:0] SYNC_TICKS = 10'h038;
  localparam logic [9:0] NIB_BASE = 10'h00C;
  localparam logic [9:0] NIB_MAX = 10'h01B;
  localparam logic [9:0] PAUSE_MIN = 10'h00C;
  localparam logic [9:0] PAUSE_MAX = 10'h300;
  localparam logic [9:0] LOW_TICKS = 10'h004;
  localparam logic [15:0] FRAME_CAP = 16'h07FF;
  localparam logic [2:0] NIBS_MIN = 3'h3;
  localparam logic [2:0] NIBS_MAX = 3'h6;
  localparam logic [3:0] CRC_SEED = 4'h5;
  localparam logic [4:0] CRC_POLY = 5'h1D;

  typedef enum logic [1:0] {TX_IDLE, TX_RUN, TX_TAIL} snl_tx_st_t;
  typedef enum logic [1:0] {RX_HUNT, RX_NIB, RX_PAUSE} snl_rx_st_t;

  // multiply a crc remainder by x^4 modulo the crc polynomial
  function automatic logic [3:0] snl_mulx4(input logic [3:0] c);
    logic [4:0] r;
    r = {1'b0, c};
    for (int i = 0; i < 4; i++) begin
      r = {r[3:0], 1'b0};
      if (r[4]) begin
        r = r ^ CRC_POLY;
      end
    end
    return r[3:0];
  endfunction

  // crc over the first n data nibbles, augmented with a zero nibble
  function automatic logic [3:0] snl_crc(input logic [23:0] d, input logic [2:0] n);
    logic [3:0] c;
    c = CRC_SEED;
    for (int i = 0; i < 6; i++) begin
      if (i < int'(n)) begin
        c = snl_mulx4(c) ^ d[23 - 4 * i -: 4];
      end
    end
    return snl_mulx4(c);
  endfunction

  // clamp the nibble count field to the served range
  function automatic logic [2:0] snl_nibs(input logic [2:0] f);
    return (f < NIBS_MIN) ? NIBS_MIN : (f > NIBS_MAX) ? NIBS_MAX : f;
  endfunction

  // interval in clocks to rounded ticks, scaled by a 56 tick sync
  function automatic logic [9:0] snl_ticks(input logic [15:0] m, input logic [15:0] s);
    logic [23:0] num;
    logic [23:0] q;
    num = 24'(m) * 24'h000070 + 24'(s);
    q = (s == 16'h0000) ? 24'hFFFFFF : num / {7'h00, s, 1'b0};
    return (q > 24'h0003FF) ? 10'h3FF : q[9:0];
  endfunction

endpackage

/* tb/snl_far_end.sv */
`timescale 1ns/1ps
module snl_far_end (
  input wire logic mclk,
  input wire logic line_in,
  output logic line_out
);
  int cyc = 0;
  int falls[$];
  logic prev_q = 1'b1;

  // stamp every falling edge of the transmit line; intervals are differences
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    prev_q <= line_in;
    if (prev_q === 1'b1 && line_in === 1'b0) begin
      falls.push_back(cyc);
    end
  end

  // idle line sits at the pull-up level between frames
  initial line_out = 1'b1;

  // one interval: four ticks low, then released high until the next fall
  task automatic pulse(input int ticks, input int t);
    line_out <= 1'b0;
    repeat (4 * t) @(posedge mclk);
    line_out <= 1'b1;
    repeat ((ticks - 4) * t) @(posedge mclk);
  endtask

  // whole frame at t clocks per tick; t off nominal models a drifting sensor
  // p above zero adds a pause of p ticks after the crc nibble
  task automatic send(input int t, input int q[$], input int p);
    @(posedge mclk);
    pulse(56, t);
    foreach (q[i]) pulse(q[i] + 12, t);
    if (p > 0) pulse(p, t);
    line_out <= 1'b0; // closing fall ends the last interval
    repeat (4 * t) @(posedge mclk);
    line_out <= 1'b1;
  endtask
endmodule

/* tb/snl_link_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin mismatches++; \
  $display("unexpected %s expected %0h seen %0h", nm, ex, gt); end end
module snl_link_tb;
  import snl_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic [2:0] bus_addr = 3'h0;
  logic [15:0] bus_wdata = 16'h0000;
  logic bus_we = 1'b0;
  logic bus_re = 1'b0;
  logic [15:0] bus_rdata;
  logic sent_rx_in;
  logic sent_tx_out;
  logic frame_done;
  logic [15:0] rv;
  int mismatches = 0;
  int compares = 0;
  int done_cnt = 0;
  int done_base = 0;

  snl_link snl_link_i (.mclk(mclk), .rstn(rstn), .ce(ce), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_we(bus_we), .bus_re(bus_re), .bus_rdata(bus_rdata), .sent_rx_in(sent_rx_in),
    .sent_tx_out(sent_tx_out), .frame_done(frame_done));
  snl_far_end snl_far_end_i (.mclk(mclk), .line_in(sent_tx_out), .line_out(sent_rx_in));

  initial begin
    forever #5 mclk = ~mclk;
  end

  // completion pulses, counted per scenario
  always @(posedge mclk) begin
    if (frame_done === 1'b1) done_cnt <= done_cnt + 1;
  end

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // single-cycle strobes, changed just after the edge
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_we <= 1'b1;
    @(posedge mclk);
    bus_we <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge mclk);
    bus_addr <= a;
    bus_re <= 1'b1;
    @(posedge mclk);
    bus_re <= 1'b0;
    #1 d = bus_rdata;
  endtask

  // reference crc: seed 5, x4+x3+x2+1, one zero nibble appended
  function automatic int mx4(input int c);
    for (int k = 0; k < 4; k++) begin
      c = c << 1;
      if (c & 16) c = c ^ 29;
    end
    return c;
  endfunction

  function automatic int crc4(input int q[$]);
    int c;
    c = 5;
    foreach (q[i]) c = mx4(c) ^ q[i];
    return mx4(c);
  endfunction

  task automatic wait_falls(input int cnt);
    int k;
    k = 0;
    while (snl_far_end_i.falls.size() < cnt) begin
      @(posedge mclk);
      k++;
      if (k > 20000) begin
        mismatches++;
        end_of_test();
      end
    end
  endtask

  // one transmitted frame at three clocks per tick, intervals against the model
  task automatic tx_frame(input logic [15:0] ctl, input int frm);
    int dh, dl, p, k, n;
    int d[$];
    int w[$];
    n = int'(ctl[2:0]);
    dh = $urandom & 16'hFFFF;
    dl = $urandom & 16'hFFFF;
    for (k = 1; k <= n; k++) d.push_back(k <= 3 ? (dh >> (12 - 4 * k)) & 15 : (dl >> (28 - 4 * k)) & 15);
    w = {56, (dh >> 12) + 12};
    foreach (d[i]) w.push_back(d[i] + 12);
    w.push_back((ctl[CTL_CRC] ? crc4(d) : dl & 15) + 12);
    if (ctl[CTL_PSE]) begin
      p = (frm > 2047 ? 0 : frm) - w.sum();
      w.push_back(p < 12 ? 12 : p > 768 ? 768 : p);
    end
    // data goes in only while the link is stopped, so no frame sees a torn update
    wr(REG_CTL, 16'h0000);
    wr(REG_TICK, 16'h0002);
    wr(REG_FRAME, 16'(frm));
    wr(REG_DATH, 16'(dh));
    wr(REG_DATL, 16'(dl));
    snl_far_end_i.falls.delete();
    wr(REG_CTL, ctl);
    if (ctl[CTL_TRG]) begin
      repeat (50) @(posedge mclk);
      `CHK("fall before trigger", 0, snl_far_end_i.falls.size())
      done_base = done_cnt;
      wr(REG_STAT, 16'h0001);
    end
    wait_falls(w.size() + 1);
    foreach (w[i]) `CHK("interval", w[i] * 3, snl_far_end_i.falls[i + 1] - snl_far_end_i.falls[i])
  endtask

  // one received frame; bad 1 spoils the crc, bad 2 stretches a data nibble to 30 ticks,
  // bad 3 adds a legal 20 tick pause, bad 4 a pause of 8 ticks that must be refused
  task automatic rx_frame(input int t, input int n, input int bad);
    int d[$];
    int q[$];
    int e[8];
    int k;
    wr(REG_CTL, 16'h8900 | 16'(n) | (bad >= 3 ? 16'h0080 : 16'h0000));
    wr(REG_STAT, 16'h000E);
    done_base = done_cnt;
    for (k = 0; k < n; k++) d.push_back($urandom & 15);
    q = {$urandom & 15};
    q = {q, d, crc4(d) ^ (bad == 1)};
    if (bad == 2) q[2] = 18;
    e[0] = q[0];
    for (k = 0; k < 6; k++) e[k + 1] = k < n ? d[k] : 0;
    e[7] = q[q.size() - 1];
    snl_far_end_i.send(t, q, bad == 3 ? 20 : bad == 4 ? 8 : 0);
    repeat (5) @(posedge mclk);
    rd(REG_STAT, rv);
    `CHK("status flags", 16'(bad == 2 ? 8 : bad == 1 ? 6 : bad == 4 ? 10 : 2), rv & 16'h000E)
    `CHK("done pulses", bad == 2 ? 0 : 1, done_cnt - done_base)
    if (bad == 0 || bad == 3) begin
      rd(REG_SYNC, rv);
      `CHK("sync capture", 16'(56 * t), rv)
      rd(REG_DATH, rv);
      `CHK("data high", 16'((e[0] << 12) | (e[1] << 8) | (e[2] << 4) | e[3]), rv)
      rd(REG_DATL, rv);
      `CHK("data low", 16'((e[4] << 12) | (e[5] << 8) | (e[6] << 4) | e[7]), rv)
    end
  endtask

  initial begin
    void'($urandom(32'h7C6C));
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    rd(REG_CTL, rv);
    `CHK("control after reset", 16'h0000, rv)
    rd(REG_INFO, rv);
    `CHK("both sides idle after reset", 16'h0000, rv)
    wr(REG_SYNC, 16'h1234);
    rd(REG_SYNC, rv);
    `CHK("sync not writable", 16'h0000, rv)
    // continuous, hardware crc, every nibble count
    for (int n = 3; n <= 6; n++) tx_frame(16'h8100 | 16'(n), 0);
    // 100 sits below the software minimum on purpose: the pause must still hold 12
    tx_frame(16'h8184, 400);
    tx_frame(16'h8184, 100);
    tx_frame(16'h8184, 3000);
    tx_frame(16'h8184, 1000);
    tx_frame(16'h8006, 0);
    // triggered: exactly one frame and one completion pulse
    tx_frame(16'h8503, 0);
    repeat (2000) @(posedge mclk);
    `CHK("falls of one frame", 7, snl_far_end_i.falls.size())
    `CHK("tx done pulses", 1, done_cnt - done_base)
    rd(REG_STAT, rv);
    `CHK("trigger cleared", 16'h0000, rv & 16'h0001)
    wr(REG_CTL, 16'h8600);
    repeat (5) @(posedge mclk);
    `CHK("idle low", 1'b0, sent_tx_out)
    wr(REG_CTL, 16'h8400);
    repeat (5) @(posedge mclk);
    `CHK("idle high", 1'b1, sent_tx_out)
    // nominal sync 336 clocks, limits at plus and minus twenty percent
    wr(REG_TICK, 16'h0193);
    wr(REG_FRAME, 16'h010D);
    rx_frame(6, 3, 0);
    rx_frame(7, 6, 0);
    rx_frame(5, 4, 0);
    rx_frame(6, 5, 1);
    rx_frame(6, 4, 2);
    rx_frame(6, 4, 0);
    rx_frame(6, 3, 3);
    rx_frame(6, 5, 4);
    // clock enable low: a write must be ignored while everything is frozen
    @(posedge mclk);
    ce <= 1'b0;
    wr(REG_TICK, 16'h0000);
    repeat (5) @(posedge mclk);
    ce <= 1'b1;
    rd(REG_TICK, rv);
    `CHK("tick kept under frozen enable", 16'h0193, rv)
    end_of_test();
  end
endmodule
